//--- hw/cfg_word_pkg.sv
// package with configuration word layout, addresses and reset timing constants
package cfg_word_pkg;
	localparam logic [13:0] CFG_SPACE_LO = 14'h2000;
	localparam logic [13:0] CFG_SPACE_HI = 14'h3FFF;
	localparam logic [13:0] CFG_WORD_ONE_ADDR = 14'h2007;
	localparam logic [13:0] CFG_WORD_TWO_ADDR = 14'h2008;
	localparam logic [15:0] CFG_ERASED = 16'hFFFF;
	localparam logic [15:0] CFG_UNIMPL_MASK = 16'hC000;
	localparam int BIT_DEBUG = 13;
	localparam int BIT_LVP = 12;
	localparam int BIT_FCM = 11;
	localparam int BIT_INT_EXT_SWITCHOVER_ENABLE = 10;
	localparam int BIT_BOR_HI = 9;
	localparam int BIT_BOR_LO = 8;
	localparam int BIT_DPROT = 7;
	localparam int BIT_PPROT = 6;
	localparam int BIT_MASTER_CLEAR = 5;
	localparam int BIT_POWERUP_TIMER = 4;
	localparam int BIT_WDT = 3;
	localparam logic [1:0] BOR_ALWAYS = 2'h3;
	localparam logic [1:0] BOR_RUN_ONLY = 2'h2;
	localparam logic [1:0] BOR_SOFTWARE = 2'h1;
	localparam logic [1:0] BOR_OFF = 2'h0;
	localparam int CLK_MHZ = 100;
	localparam int POWERUP_TIMER_MS = 64;
	localparam int POWERUP_TIMER_CYCLES = POWERUP_TIMER_MS * 1000 * CLK_MHZ;
endpackage

//--- hw/cfg_delay_timer.sv
// down counter that holds a busy flag high for a programmable number of cycles
`timescale 1ns/10ps
module cfg_delay_timer #(
	parameter int WIDTH = 24
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_start,
	input wire logic [WIDTH-1:0] i_count,
	output logic o_busy
);
	typedef struct packed {
		logic [WIDTH-1:0] cnt;
		logic busy;
	} tmr_state_t;
	tmr_state_t st;
	tmr_state_t next_st;

	initial begin
		if (WIDTH < 2)
			$error("cfg_delay_timer: WIDTH too small");
	end

	// start reloads; otherwise count down to one and drop busy
	always_comb begin
		next_st = st;
		if (i_start) begin
			next_st.cnt = i_count;
			next_st.busy = (i_count != '0);
		end else if (st.busy) begin
			if (st.cnt <= WIDTH'(1))
				next_st.busy = 1'b0;
			next_st.cnt = st.cnt - WIDTH'(1);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			st <= '0;
		else
			st <= next_st;
	end

	assign o_busy = st.busy;
endmodule

//--- hw/config_word_reset_options.sv
// configuration word one holder, option decode, reset delay sequencing and sleep wake
// Summary of operation
// - a programmed bit reads zero, erased bit reads one; erased word gives defaults
// - word one lives at 2007h, word two at 2008h
// - space 2000h-3FFFh is reachable only in a programming session
// - bit 13 low gives both debug pins to the debugger
// - bit 12 high makes program-mode pin the low-voltage programming trigger
// - bit 11 high enables the fail-safe clock monitor
// - bit 10 high enables internal/external oscillator switchover
// - power-up timer holds reset 64 ms after power-up, and after brown-out when enabled
// - brown-out reset may reuse the power-up timer for 64 ms hold
// - start-up timer holds reset until crystal oscillator is stable
// - sleep ends on external reset, watchdog wake-up, or interrupt
// - bits 9-8 pick brown-out: always, run only, software, off
// - bit 4 low enables the power-up timer
// - bit 3 high forces watchdog on; low leaves it to software
// - bit 5 high makes master-clear pin a reset; low makes it input
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
module config_word_reset_options
	import cfg_word_pkg::*;
#(
	// power-up delay in core clock cycles; the default is the nominal delay at the 100 MHz core clock
	parameter int POWERUP_TIMER_COUNT = POWERUP_TIMER_CYCLES,
	// width of the power-up down counter; it must hold the delay count
	parameter int CNT_WIDTH = 24
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// programming port, reached only inside a programming session
	input wire logic [13:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	input wire logic i_prog_session,
	// asynchronous pins and events, each except i_crystal_mode passed through a synchroniser
	input wire logic i_brownout_event,
	input wire logic i_osc_stable,
	input wire logic i_crystal_mode,
	input wire logic i_master_clear_pin,
	input wire logic i_watchdog_wake,
	input wire logic i_interrupt_wake,
	// same-clock requests and software enables
	input wire logic i_sleep_req,
	input wire logic i_software_brownout_enable,
	input wire logic i_software_watchdog_enable,
	// options decoded from the held word
	output logic o_debug_enable,
	output logic o_low_volt_prog_enable,
	output logic o_failsafe_clock_monitor_enable,
	output logic o_int_ext_switchover_enable,
	output logic o_brownout_active,
	output logic o_watchdog_active,
	output logic o_master_clear_pin_is_reset,
	output logic o_data_mem_protect,
	output logic o_program_mem_protect,
	// reset and sleep status for the core
	output logic o_core_reset,
	output logic o_sleeping
);
	// reset sequencer: power-on latch, power-up delay, start-up wait, run
	typedef enum logic [3:0] {
		SEQ_POR = 4'h1,
		SEQ_POWERUP_TIMER = 4'h2,
		SEQ_OST = 4'h4,
		SEQ_RUN = 4'h8
	} seq_t;

	// every register of the block except the power-up timer's counter and busy flag in one set
	typedef struct packed {
		// stored words behave like nonvolatile cells and survive reset
		logic [15:0] nv_one;
		logic [15:0] nv_two;
		// held options, loaded only at power-on
		logic [15:0] cfg;
		// programming read data, standing for one cycle
		logic [15:0] rdata;
		// sequencer and sleep state
		seq_t seq;
		logic sleeping;
		// pin synchronisers and their settled levels
		logic [2:0] master_clear_sync;
		logic [2:0] bor_sync;
		logic [2:0] osc_sync;
		logic [2:0] wake_sync;
		logic master_clear_level;
		logic bor_level;
		logic osc_level;
		logic wake_level;
	} ctl_state_t;
	ctl_state_t st;
	ctl_state_t next_st;

	logic powerup_timer_start;
	logic powerup_timer_busy;
	logic bor_trip;
	logic master_clear_trip;
	logic powerup_timer_on_por;
	logic powerup_timer_on_bor;
	logic wake_trip;

	// word select codes of the programming port decode
	localparam logic [1:0] SEL_NONE = 2'h0;
	localparam logic [1:0] SEL_ONE = 2'h1;
	localparam logic [1:0] SEL_TWO = 2'h2;

	initial begin
		if (CNT_WIDTH < 2 || CNT_WIDTH > 31)
			$error("config_word_reset_options: CNT_WIDTH out of range");
		if (POWERUP_TIMER_COUNT < 1 || POWERUP_TIMER_COUNT >= (1 << CNT_WIDTH))
			$error("config_word_reset_options: POWERUP_TIMER_COUNT does not fit");
		if (CFG_WORD_ONE_ADDR < CFG_SPACE_LO || CFG_WORD_TWO_ADDR > CFG_SPACE_HI)
			$error("config_word_reset_options: word addresses outside the configuration space");
	end

	// configuration space decode, shared by the read and write paths
	function automatic logic in_cfg_space(input logic [13:0] a);
		return (a >= CFG_SPACE_LO) && (a <= CFG_SPACE_HI);
	endfunction

	// word select, shared by the write and read paths
	function automatic logic [1:0] word_sel(input logic [13:0] a);
		if (a == CFG_WORD_ONE_ADDR)
			return SEL_ONE;
		if (a == CFG_WORD_TWO_ADDR)
			return SEL_TWO;
		return SEL_NONE;
	endfunction

	// brown-out enable from the two-bit field; run-only mode drops out in sleep
	function automatic logic bor_enabled(input logic [1:0] mode, input logic sw, input logic slp);
		case (mode)
			BOR_ALWAYS: return 1'b1;
			BOR_RUN_ONLY: return !slp;
			BOR_SOFTWARE: return sw;
			default: return 1'b0;
		endcase
	endfunction

	// the held option word drives every decoded output
	assign o_debug_enable = !st.cfg[BIT_DEBUG];
	assign o_low_volt_prog_enable = st.cfg[BIT_LVP];
	assign o_failsafe_clock_monitor_enable = st.cfg[BIT_FCM];
	assign o_int_ext_switchover_enable = st.cfg[BIT_INT_EXT_SWITCHOVER_ENABLE];
	// pin function and code protection; a programmed protect bit turns protection on
	assign o_master_clear_pin_is_reset = st.cfg[BIT_MASTER_CLEAR];
	assign o_data_mem_protect = !st.cfg[BIT_DPROT];
	assign o_program_mem_protect = !st.cfg[BIT_PPROT];
	// software enables act at once, so these two stay combinational
	assign o_watchdog_active = st.cfg[BIT_WDT] | i_software_watchdog_enable;
	assign o_brownout_active = bor_enabled(st.cfg[BIT_BOR_HI:BIT_BOR_LO],
		i_software_brownout_enable, st.sleeping);
	// status: the core stays in reset until the sequencer runs
	assign o_core_reset = (st.seq != SEQ_RUN);
	assign o_sleeping = st.sleeping;
	assign o_rdata = st.rdata;

	// a tripped brown-out counts only while enabled; pin reset only when the pin is a reset
	assign bor_trip = st.bor_level & o_brownout_active;
	assign master_clear_trip = !st.master_clear_level & st.cfg[BIT_MASTER_CLEAR];
	// power-on reads the stored word: the held options only load on that same edge
	assign powerup_timer_on_por = !st.nv_one[BIT_POWERUP_TIMER];
	// a brown-out restart reads the held options, settled long before
	assign powerup_timer_on_bor = !st.cfg[BIT_POWERUP_TIMER];
	// either wake source counts once its settled level is up
	assign wake_trip = st.sleeping & st.wake_level;

	// power-up timer reloads on entry to its state; powerup_timer bit low enables it
	assign powerup_timer_start = (next_st.seq == SEQ_POWERUP_TIMER) && (st.seq != SEQ_POWERUP_TIMER);

	cfg_delay_timer #(
		.WIDTH(CNT_WIDTH)
	) u_powerup_timer (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_start(powerup_timer_start),
		.i_count(CNT_WIDTH'(POWERUP_TIMER_COUNT)),
		.o_busy(powerup_timer_busy)
	);

	// next-state logic: synchronisers, programming access, reset sequencer, sleep
	always_comb begin
		next_st = st;
		// pins pass three flops; a change counts once the last two agree
		next_st.master_clear_sync = {st.master_clear_sync[1:0], i_master_clear_pin};
		next_st.bor_sync = {st.bor_sync[1:0], i_brownout_event};
		next_st.osc_sync = {st.osc_sync[1:0], i_osc_stable};
		next_st.wake_sync = {st.wake_sync[1:0], i_watchdog_wake | i_interrupt_wake};
		if (st.master_clear_sync[2] == st.master_clear_sync[1])
			next_st.master_clear_level = st.master_clear_sync[2];
		if (st.bor_sync[2] == st.bor_sync[1])
			next_st.bor_level = st.bor_sync[2];
		if (st.osc_sync[2] == st.osc_sync[1])
			next_st.osc_level = st.osc_sync[2];
		if (st.wake_sync[2] == st.wake_sync[1])
			next_st.wake_level = st.wake_sync[2];

		// programming port: only a session reaches the configuration space
		next_st.rdata = '0;
		if (i_prog_session && in_cfg_space(i_addr)) begin
			// programming clears bits only; erase is outside this block
			if (i_wr) begin
				case (word_sel(i_addr))
					SEL_ONE: next_st.nv_one = (st.nv_one & i_wdata) | CFG_UNIMPL_MASK;
					SEL_TWO: next_st.nv_two = st.nv_two & i_wdata;
					// other cells of the space are not held here
					default: ;
				endcase
			end
			// read data stand for one cycle only, then return to zero
			if (i_rd) begin
				case (word_sel(i_addr))
					SEL_ONE: next_st.rdata = st.nv_one;
					SEL_TWO: next_st.rdata = st.nv_two;
					// unprogrammed locations of the space read as erased
					default: next_st.rdata = CFG_ERASED;
				endcase
			end
		end

		// reset sequencer; brown-out and pin reset restart it without a new latch
		case (st.seq)
			// power-on: latch the options and pick the first delay from the stored word
			SEQ_POR: begin
				next_st.cfg = st.nv_one;
				if (powerup_timer_on_por)
					next_st.seq = SEQ_POWERUP_TIMER;
				else
					next_st.seq = SEQ_OST;
			end
			// power-up delay: the timer loads on the entry edge, so busy is up from the first cycle
			SEQ_POWERUP_TIMER: begin
				if (!powerup_timer_busy)
					next_st.seq = SEQ_OST;
			end
			// start-up wait: a crystal must report stable, other clock sources pass at once
			SEQ_OST: begin
				if (!i_crystal_mode || st.osc_level)
					next_st.seq = SEQ_RUN;
			end
			// running: sleep on request; a settled wake level ends sleep and is never missed
			SEQ_RUN: begin
				if (i_sleep_req)
					next_st.sleeping = 1'b1;
				if (wake_trip)
					next_st.sleeping = 1'b0;
			end
			// an illegal code restarts the whole power-on sequence
			default: next_st.seq = SEQ_POR;
		endcase

		// external reset wakes from sleep by restarting without the power-up delay
		if (master_clear_trip) begin
			next_st.sleeping = 1'b0;
			next_st.seq = SEQ_OST;
		end
		// brown-out uses the power-up timer when that timer is enabled
		if (bor_trip) begin
			next_st.sleeping = 1'b0;
			next_st.seq = powerup_timer_on_bor ? SEQ_POWERUP_TIMER : SEQ_OST;
		end
	end

	// power-on reset: the stored word is kept, the options reload from it
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			st.cfg <= CFG_ERASED;
			st.rdata <= '0;
			st.seq <= SEQ_POR;
			st.sleeping <= 1'b0;
			// synchronisers park at their pins' idle levels, so no false trip follows reset
			st.master_clear_sync <= 3'h7;
			st.bor_sync <= 3'h0;
			st.osc_sync <= 3'h0;
			st.wake_sync <= 3'h0;
			st.master_clear_level <= 1'b1;
			st.bor_level <= 1'b0;
			st.osc_level <= 1'b0;
			st.wake_level <= 1'b0;
			// stored words carry on through reset; a write in a reset cycle still lands
			st.nv_one <= next_st.nv_one;
			st.nv_two <= next_st.nv_two;
		end else begin
			st <= next_st;
		end
	end
endmodule

//--- sim/cfg_word_assertions.sv
// port-level checks for the configuration word block
`timescale 1ns/10ps
module cfg_word_assertions
	import cfg_word_pkg::*;
#(
	parameter int POWERUP_TIMER_COUNT = 20
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic [13:0] i_addr,
	input wire logic i_rd,
	input wire logic i_prog_session,
	input wire logic i_osc_stable,
	input wire logic i_crystal_mode,
	input wire logic i_watchdog_wake,
	input wire logic i_interrupt_wake,
	input wire logic i_software_watchdog_enable,
	input wire logic [15:0] o_rdata,
	input wire logic o_debug_enable,
	input wire logic o_low_volt_prog_enable,
	input wire logic o_brownout_active,
	input wire logic o_watchdog_active,
	input wire logic o_master_clear_pin_is_reset,
	input wire logic o_core_reset,
	input wire logic o_sleeping
);
	// one domain, so clock and reset are given once
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	// a refused read must never leak stored bits
	refused_read_a: assert property ($past(i_rd) && (!$past(i_prog_session) || $past(i_addr) < CFG_SPACE_LO)
		|-> o_rdata == 16'h0000) else $error("refused read returned data");
	erased_defaults_a: assert property ($fell(i_rst) |-> !o_debug_enable && o_low_volt_prog_enable
		&& o_master_clear_pin_is_reset) else $error("options not erased during reset");
	options_held_a: assert property (!$past(i_rst) && !$past(i_rst, 2) |-> o_debug_enable === $past(o_debug_enable)
		&& o_low_volt_prog_enable === $past(o_low_volt_prog_enable)) else $error("option changed while running");
	soft_watchdog_a: assert property (i_software_watchdog_enable |-> o_watchdog_active)
		else $error("software watchdog enable ignored");
	wake_irq_a: assert property (o_sleeping && i_interrupt_wake |-> ##[1:6] !o_sleeping)
		else $error("interrupt did not wake");
	wake_wdt_a: assert property (o_sleeping && i_watchdog_wake |-> ##[1:6] !o_sleeping)
		else $error("watchdog did not wake");
	osc_wait_a: assert property ($fell(o_core_reset) && i_crystal_mode |-> $past(i_osc_stable, 2))
		else $error("reset left before oscillator stable");
	pin_input_a: assert property (!o_master_clear_pin_is_reset && !o_brownout_active && !o_core_reset
		|=> !o_core_reset) else $error("reset while pin is plain input");
endmodule

//--- sim/cfg_programmer.sv
// programmer model: one strobe per access, address and data scrambled when idle
`timescale 1ns/10ps
module cfg_programmer (
	input wire logic i_sys_clk,
	input wire logic [15:0] i_rdata,
	output logic [13:0] o_addr,
	output logic [15:0] o_wdata,
	output logic o_wr,
	output logic o_rd,
	output logic o_session
);
	initial begin
		o_addr = 14'h1555;
		o_wdata = 16'hAAAA;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_session = 1'b0;
	end
	// the config space is only reached inside a programming session
	task automatic set_session(input logic s);
		@(posedge i_sys_clk);
		o_session <= s;
	endtask
	// inverted leftovers keep a stale address from passing for a held one
	task automatic access(input logic wr, input logic [13:0] a, input logic [15:0] d, output logic [15:0] q);
		@(posedge i_sys_clk);
		o_wr <= wr;
		o_rd <= !wr;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_sys_clk);
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
		#1 q = i_rdata;
	endtask
endmodule

//--- sim/test_config_word_reset_options.sv
// self-checking bench for the configuration word block
`timescale 1ns/10ps
module test_config_word_reset_options;
	import cfg_word_pkg::*;
	logic i_sys_clk = 1'b0, i_rst = 1'b1, i_wr, i_rd, i_prog_session;
	logic [13:0] i_addr;
	logic [15:0] i_wdata, o_rdata;
	logic i_brownout_event = 1'b0, i_osc_stable = 1'b1, i_crystal_mode = 1'b0, i_master_clear_pin = 1'b1;
	logic i_watchdog_wake = 1'b0, i_interrupt_wake = 1'b0, i_sleep_req = 1'b0;
	logic i_software_brownout_enable = 1'b0, i_software_watchdog_enable = 1'b0;
	logic o_debug_enable, o_low_volt_prog_enable, o_failsafe_clock_monitor_enable, o_int_ext_switchover_enable;
	logic o_brownout_active, o_watchdog_active, o_master_clear_pin_is_reset, o_data_mem_protect;
	logic o_program_mem_protect, o_core_reset, o_sleeping;
	int w1 = 0, w2 = 0, error_cnt = 0, num_checks = 0, seed = 33033;
	bit sess = 0;
	always #5 i_sys_clk = ~i_sys_clk;
	config_word_reset_options #(.POWERUP_TIMER_COUNT(20)) u_config_word_reset_options (.*);
	cfg_programmer pm (.i_sys_clk, .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr),
		.o_rd(i_rd), .o_session(i_prog_session));
	// expected read data: refused gives zero, unused space reads erased
	function automatic int model(input int a);
		if (!sess || a < CFG_SPACE_LO) return 0;
		if (a == CFG_WORD_ONE_ADDR) return w1;
		if (a == CFG_WORD_TWO_ADDR) return w2;
		return 32'h0000FFFF;
	endfunction
	function automatic logic [15:0] opts();
		return {9'h000, o_debug_enable, o_low_volt_prog_enable, o_failsafe_clock_monitor_enable,
			o_int_ext_switchover_enable, o_master_clear_pin_is_reset, o_data_mem_protect, o_program_mem_protect};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			error_cnt++;
		end
	endtask
	// writes only clear bits, so the model ands them in
	task automatic op(input logic wr, input logic [13:0] a, input logic [15:0] d);
		logic [15:0] q;
		pm.access(wr, a, d, q);
		if (wr && sess && a == CFG_WORD_ONE_ADDR) w1 = (w1 & d) | 32'h0000C000;
		if (wr && sess && a == CFG_WORD_TWO_ADDR) w2 = w2 & d;
		if (!wr) chk(q, 16'(model(a)));
	endtask
	task automatic wait_low(ref logic s, input int n);
		int k;
		k = 0;
		while (s !== 1'b0 && k < n) begin
			@(posedge i_sys_clk);
			#1;
			k++;
		end
		chk(16'(s), 16'h0000);
		if (s !== 1'b0) test_done();
	endtask
	task automatic do_reset();
		i_rst <= 1'b1;
		repeat (6) @(posedge i_sys_clk);
		i_rst <= 1'b0;
	endtask
	task automatic test_done();
		if (error_cnt == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// main sequence: program, probe the space, reboot on the new word, then sleep and wake
	initial begin
		do_reset();
		pm.set_session(1'b1);
		sess = 1;
		op(1, CFG_WORD_ONE_ADDR, 16'h0000);
		op(1, CFG_WORD_TWO_ADDR, 16'h0000);
		op(0, CFG_WORD_ONE_ADDR, 16'h0000);
		op(0, CFG_WORD_TWO_ADDR, 16'h0000);
		op(0, 14'h1FFF, 16'h0000);
		repeat (12) op(1'($random(seed)), CFG_SPACE_LO | 14'($random(seed)), 16'($random(seed)));
		pm.set_session(1'b0);
		sess = 0;
		op(0, CFG_WORD_ONE_ADDR, 16'h0000);
		i_crystal_mode <= 1'b1;
		i_osc_stable <= 1'b0;
		do_reset();
		#1 chk(opts(), 16'h003C);
		repeat (20) @(posedge i_sys_clk);
		#1 chk(16'(o_core_reset), 16'h0001);
		@(posedge i_sys_clk);
		i_osc_stable <= 1'b1;
		wait_low(o_core_reset, 50);
		chk(opts(), 16'h0043);
		chk(16'(o_brownout_active), 16'h0000);
		for (int s = 0; s < 2; s++) begin
			@(posedge i_sys_clk);
			i_software_watchdog_enable <= s[0];
			@(posedge i_sys_clk);
			#1 chk(16'(o_watchdog_active), 16'(s));
		end
		@(posedge i_sys_clk);
		i_master_clear_pin <= 1'b0;
		i_brownout_event <= 1'b1;
		repeat (10) @(posedge i_sys_clk);
		#1 chk(16'(o_core_reset), 16'h0000);
		for (int w = 0; w < 2; w++) begin
			@(posedge i_sys_clk);
			i_master_clear_pin <= 1'b1;
			i_brownout_event <= 1'b0;
			i_sleep_req <= 1'b1;
			@(posedge i_sys_clk);
			i_sleep_req <= 1'b0;
			repeat (2) @(posedge i_sys_clk);
			#1 chk(16'(o_sleeping), 16'h0001);
			@(posedge i_sys_clk);
			i_watchdog_wake <= (w == 0);
			i_interrupt_wake <= (w == 1);
			wait_low(o_sleeping, 10);
			@(posedge i_sys_clk);
			i_watchdog_wake <= 1'b0;
			i_interrupt_wake <= 1'b0;
			// let the synchronised wake level fall back before the next sleep
			repeat (6) @(posedge i_sys_clk);
		end
		// reboot without a crystal: only the power-up delay chosen by the stored word holds reset
		i_crystal_mode <= 1'b0;
		do_reset();
		repeat (20) @(posedge i_sys_clk);
		#1 chk(16'(o_core_reset), 16'h0001);
		wait_low(o_core_reset, 10);
		test_done();
	end
endmodule
bind config_word_reset_options cfg_word_assertions #(.POWERUP_TIMER_COUNT(POWERUP_TIMER_COUNT)) chk_i (.i_sys_clk, .i_rst, .i_addr,
	.i_rd, .i_prog_session, .i_osc_stable, .i_crystal_mode, .i_watchdog_wake, .i_interrupt_wake,
	.i_software_watchdog_enable, .o_rdata, .o_debug_enable, .o_low_volt_prog_enable, .o_brownout_active,
	.o_watchdog_active, .o_master_clear_pin_is_reset, .o_core_reset, .o_sleeping);
